// [cnms_top.sv]
// motion sequencer: continuous run, live speed change, ramp derivation, nudge moves, teaching
// assumes discrete pins from an unrelated domain and a classic wishbone master on SYS_CLK
//
// Chosen here: register access over Wishbone and the placing of the registers.
module cnms_top import cnms_pkg::*; #(
  parameter int unsigned TICK_CYC = TICK_TIME_NS / CLK_PERIOD_NS,
  parameter int unsigned STEP_CLK_HZ = SEC_NS / CLK_PERIOD_NS
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_STB_I,
  input wire logic WB_CYC_I,
  output logic WB_ACK_O,
  input wire logic FORWARD_RUN_IN,
  input wire logic REVERSE_RUN_IN,
  input wire logic DATA_SELECT_B0,
  input wire logic DATA_SELECT_B1,
  input wire logic DATA_SELECT_B2,
  input wire logic DATA_SELECT_B3,
  input wire logic DATA_SELECT_B4,
  input wire logic DATA_SELECT_B5,
  input wire logic STEP_NUDGE_POS,
  input wire logic STEP_NUDGE_NEG,
  output logic READY_OUT,
  output logic MOVE_OUT,
  output logic STEP_OUT,
  output logic DIR_OUT
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clampv

  function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : wb_merge

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [9:0] pin_raw;
  logic [9:0] meta_ff;
  logic [9:0] sync_ff;
  assign pin_raw = {STEP_NUDGE_NEG, STEP_NUDGE_POS, REVERSE_RUN_IN, FORWARD_RUN_IN, DATA_SELECT_B5,
                    DATA_SELECT_B4, DATA_SELECT_B3, DATA_SELECT_B2, DATA_SELECT_B1, DATA_SELECT_B0};

  // two flops per pin; only the second stage is read
  for (genvar g = 0; g < 10; g++) begin : g_sync
    always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
        meta_ff[g] <= 1'b0;
        sync_ff[g] <= 1'b0;
      end else begin
        meta_ff[g] <= pin_raw[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  logic [IDX_W-1:0] sel_idx;
  logic forward_run_in;
  logic rev;
  logic [1:0] nudge_prev_ff;
  assign sel_idx = sync_ff[5:0];
  assign forward_run_in = sync_ff[6];
  assign rev = sync_ff[7];

  // ****************************************************************
  // register file
  // ****************************************************************
  logic ack_ff;
  logic wb_req;
  logic wb_wr;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic [31:0] rd_ff;
  logic ramp_common_ff;
  logic unit_s_ff;
  logic teach_ff;
  logic [1:0] sw_nudge_ff;
  logic [SPD_W-1:0] start_speed_ff;
  logic [SPD_W-1:0] shared_acc_ff;
  logic [SPD_W-1:0] shared_dec_ff;
  logic [POS_W-2:0] nudge_amount_ff;
  logic [SPD_W-1:0] nudge_speed_ff;
  logic [SPD_W-1:0] nudge_start_ff;
  logic [SPD_W-1:0] nudge_ramp_ff;
  logic [IDX_W-1:0] ent_idx_ff;
  logic [POS_W-1:0] pos_ff;
  logic [SPD_W-1:0] cur_ff;
  logic dir_ff;
  logic both_seen_ff;
  logic ready_ff;
  logic move_ff;
  logic step_ff;
  logic [ENT_W-1:0] ent_a;
  logic [ENT_W-1:0] ent_b;
  cnms_state_type state_ff;
  cnms_state_type nxt_state;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  assign wb_wr = wb_req & WB_WE_I;
  assign wr_val = wb_merge(rd_mux, WB_DAT_I, WB_SEL_I);

  // read decode; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (WB_ADR_I == OFF_CTRL) begin
      rd_mux = {30'h0, unit_s_ff, ramp_common_ff};
    end else if (WB_ADR_I == OFF_STATUS) begin
      rd_mux = {24'h0, 1'b0, state_ff, both_seen_ff, dir_ff, move_ff, ready_ff};
    end else if (WB_ADR_I == OFF_START_SPEED) begin
      rd_mux = {12'h0, start_speed_ff};
    end else if (WB_ADR_I == OFF_SHARED_ACC) begin
      rd_mux = {12'h0, shared_acc_ff};
    end else if (WB_ADR_I == OFF_SHARED_DEC) begin
      rd_mux = {12'h0, shared_dec_ff};
    end else if (WB_ADR_I == OFF_NUDGE_AMOUNT) begin
      rd_mux = {9'h0, nudge_amount_ff};
    end else if (WB_ADR_I == OFF_NUDGE_SPEED) begin
      rd_mux = {12'h0, nudge_speed_ff};
    end else if (WB_ADR_I == OFF_NUDGE_START) begin
      rd_mux = {12'h0, nudge_start_ff};
    end else if (WB_ADR_I == OFF_NUDGE_RAMP) begin
      rd_mux = {12'h0, nudge_ramp_ff};
    end else if (WB_ADR_I == OFF_POSITION) begin
      rd_mux = {8'h0, pos_ff};
    end else if (WB_ADR_I == OFF_CUR_SPEED) begin
      rd_mux = {12'h0, cur_ff};
    end else if (WB_ADR_I == OFF_ENT_IDX) begin
      rd_mux = {26'h0, ent_idx_ff};
    end else if (WB_ADR_I == OFF_ENT_SPEED) begin
      rd_mux = {12'h0, ent_b[ENT_SPD_LSB +: SPD_W]};
    end else if (WB_ADR_I == OFF_ENT_ACC) begin
      rd_mux = {12'h0, ent_b[ENT_ACC_LSB +: SPD_W]};
    end else if (WB_ADR_I == OFF_ENT_DEC) begin
      rd_mux = {12'h0, ent_b[ENT_DEC_LSB +: SPD_W]};
    end else if (WB_ADR_I == OFF_ENT_POS) begin
      rd_mux = {8'h0, ent_b[ENT_POS_LSB +: POS_W]};
    end else if (WB_ADR_I == OFF_ENT_MODE) begin
      rd_mux = {31'h0, ent_b[ENT_ABS_BIT]};
    end
  end

  // one-wait-state answer; ack falls the cycle after it rose
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req;
      rd_ff <= wb_req ? rd_mux : 32'h0000_0000;
    end
  end
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rd_ff;

  // settings, clamped into their ranges on write
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ramp_common_ff <= 1'b0;
      unit_s_ff <= 1'b0;
      start_speed_ff <= RST_START;
      shared_acc_ff <= RST_RAMP;
      shared_dec_ff <= RST_RAMP;
      nudge_amount_ff <= RST_AMOUNT;
      nudge_speed_ff <= RST_SPEED;
      nudge_start_ff <= RST_START;
      nudge_ramp_ff <= RST_RAMP;
      ent_idx_ff <= '0;
    end else if (wb_wr) begin
      if (WB_ADR_I == OFF_CTRL) begin
        ramp_common_ff <= wr_val[CTRL_COMMON_BIT];
        unit_s_ff <= wr_val[CTRL_UNIT_S_BIT];
      end else if (WB_ADR_I == OFF_START_SPEED) begin
        start_speed_ff <= SPD_W'(clampv(wr_val, START_MIN, SPEED_MAX));
      end else if (WB_ADR_I == OFF_SHARED_ACC) begin
        shared_acc_ff <= SPD_W'(clampv(wr_val, RAMP_MIN, RAMP_MAX));
      end else if (WB_ADR_I == OFF_SHARED_DEC) begin
        shared_dec_ff <= SPD_W'(clampv(wr_val, RAMP_MIN, RAMP_MAX));
      end else if (WB_ADR_I == OFF_NUDGE_AMOUNT) begin
        nudge_amount_ff <= (POS_W-1)'(clampv(wr_val, AMOUNT_MIN, AMOUNT_MAX));
      end else if (WB_ADR_I == OFF_NUDGE_SPEED) begin
        nudge_speed_ff <= SPD_W'(clampv(wr_val, SPEED_MIN, SPEED_MAX));
      end else if (WB_ADR_I == OFF_NUDGE_START) begin
        nudge_start_ff <= SPD_W'(clampv(wr_val, START_MIN, SPEED_MAX));
      end else if (WB_ADR_I == OFF_NUDGE_RAMP) begin
        nudge_ramp_ff <= SPD_W'(clampv(wr_val, RAMP_MIN, RAMP_MAX));
      end else if (WB_ADR_I == OFF_ENT_IDX) begin
        ent_idx_ff <= wr_val[IDX_W-1:0];
      end
    end
  end

  // one-cycle command pulses from control writes
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      teach_ff <= 1'b0;
      sw_nudge_ff <= 2'b00;
      nudge_prev_ff <= 2'b00;
    end else begin
      teach_ff <= wb_wr & (WB_ADR_I == OFF_CTRL) & wr_val[CTRL_TEACH_BIT];
      sw_nudge_ff <= {2{wb_wr & (WB_ADR_I == OFF_CTRL)}} & wr_val[CTRL_NNEG_BIT:CTRL_NPOS_BIT];
      nudge_prev_ff <= sync_ff[9:8];
    end
  end

  // ****************************************************************
  // operation-data entries
  // ****************************************************************
  logic mem_we;
  logic [ENT_W-1:0] mem_wmask;
  logic [ENT_W-1:0] mem_wdata;

  // entry field writes and teaching capture
  always_comb begin
    mem_we = wb_wr;
    mem_wmask = '0;
    mem_wdata = '0;
    if (teach_ff) begin
      mem_we = 1'b1;
      mem_wmask[ENT_POS_LSB +: POS_W] = '1;
      mem_wmask[ENT_ABS_BIT] = 1'b1;
      mem_wdata[ENT_POS_LSB +: POS_W] = pos_ff;
      mem_wdata[ENT_ABS_BIT] = 1'b1;
    end else if (WB_ADR_I == OFF_ENT_SPEED) begin
      mem_wmask[ENT_SPD_LSB +: SPD_W] = '1;
      mem_wdata[ENT_SPD_LSB +: SPD_W] = SPD_W'(clampv(wr_val, SPEED_MIN, SPEED_MAX));
    end else if (WB_ADR_I == OFF_ENT_ACC) begin
      mem_wmask[ENT_ACC_LSB +: SPD_W] = '1;
      mem_wdata[ENT_ACC_LSB +: SPD_W] = SPD_W'(clampv(wr_val, RAMP_MIN, RAMP_MAX));
    end else if (WB_ADR_I == OFF_ENT_DEC) begin
      mem_wmask[ENT_DEC_LSB +: SPD_W] = '1;
      mem_wdata[ENT_DEC_LSB +: SPD_W] = SPD_W'(clampv(wr_val, RAMP_MIN, RAMP_MAX));
    end else if (WB_ADR_I == OFF_ENT_POS) begin
      mem_wmask[ENT_POS_LSB +: POS_W] = '1;
      mem_wdata[ENT_POS_LSB +: POS_W] = wr_val[POS_W-1:0];
    end else if (WB_ADR_I == OFF_ENT_MODE) begin
      mem_wmask[ENT_ABS_BIT] = 1'b1;
      mem_wdata[ENT_ABS_BIT] = wr_val[0];
    end else begin
      mem_we = 1'b0;
    end
  end

  cnms_entry_mem u_mem (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .we(mem_we),
    .waddr(ent_idx_ff),
    .wmask(mem_wmask),
    .wdata(mem_wdata),
    .raddr_a(sel_idx),
    .rdata_a(ent_a),
    .raddr_b(ent_idx_ff),
    .rdata_b(ent_b)
  );

  // ****************************************************************
  // ramp parameters
  // ****************************************************************
  logic [SPD_W-1:0] tgt;
  logic [SPD_W-1:0] vs;
  logic [SPD_W-1:0] floor_spd;
  logic [SPD_W-1:0] r_up;
  logic [SPD_W-1:0] r_dn;
  logic [SPD_W-1:0] goal;
  logic [ACC_W-1:0] den;
  logic [ACC_W-1:0] num;
  logic [ACC_W-1:0] racc_ff;
  logic [ACC_W-1:0] ramp_sum;
  logic ramp_hit;

  // nudge and teaching moves use their own set, continuous run the selected entry
  always_comb begin
    if (state_ff == ST_NUDGE) begin
      tgt = nudge_speed_ff;
      vs = nudge_start_ff;
      r_up = nudge_ramp_ff;
      r_dn = nudge_ramp_ff;
    end else begin
      tgt = ent_a[ENT_SPD_LSB +: SPD_W];
      vs = start_speed_ff;
      r_up = ramp_common_ff ? shared_acc_ff : ent_a[ENT_ACC_LSB +: SPD_W];
      r_dn = ramp_common_ff ? shared_dec_ff : ent_a[ENT_DEC_LSB +: SPD_W];
    end
  end
  assign floor_spd = (vs == '0) ? SPD_W'(1) : vs;

  // rate = span / time in seconds units, or 1e6/r Hz per ms in ms/kHz units
  always_comb begin
    den = ACC_W'(cur_ff < goal ? r_up : r_dn) * ACC_W'(TICK_CYC);
    if (!unit_s_ff) begin
      num = ACC_W'(MSKHZ_NUM);
    end else if (tgt > vs) begin
      num = ACC_W'(tgt - vs);
    end else begin
      num = den;
    end
  end
  assign ramp_sum = racc_ff + num;
  assign ramp_hit = ramp_sum >= den;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  logic same_on;
  logic opp_on;
  logic both_on;
  logic nudge_go;
  logic nudge_neg;
  logic moving;
  logic step_hit;
  logic nxt_dir;
  logic nxt_both;
  logic [PH_W-1:0] ph_ff;
  logic [PH_W-1:0] ph_sum;
  logic [POS_W-2:0] remain_ff;
  logic [POS_W-2:0] up_steps_ff;

  assign same_on = dir_ff ? (rev & ~forward_run_in) : (forward_run_in & ~rev);
  assign opp_on = dir_ff ? (forward_run_in & ~rev) : (rev & ~forward_run_in);
  assign both_on = forward_run_in & rev;
  assign nudge_neg = (sync_ff[9] & ~nudge_prev_ff[1]) | sw_nudge_ff[1];
  assign nudge_go = (sync_ff[8] & ~nudge_prev_ff[0]) | nudge_neg | sw_nudge_ff[0];

  // next state, target speed and direction
  always_comb begin
    nxt_state = state_ff;
    nxt_dir = dir_ff;
    nxt_both = both_seen_ff;
    goal = '0;
    case (state_ff)
      ST_IDLE: begin
        if (forward_run_in ^ rev) begin
          nxt_state = ST_LOAD;
          nxt_dir = rev;
        end else if (nudge_go) begin
          nxt_state = ST_NUDGE;
          nxt_dir = nudge_neg;
        end
      end
      ST_LOAD: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (both_on) begin
          nxt_both = 1'b1;
        end
        goal = (same_on & ~both_seen_ff & ~both_on) ? tgt : floor_spd;
        if (!same_on && cur_ff <= floor_spd && cur_ff != '0) begin
          if (both_seen_ff || both_on) begin
            nxt_state = ST_HOLD;
          end else if (opp_on) begin
            nxt_state = ST_LOAD;
            nxt_dir = ~dir_ff;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (!forward_run_in && !rev) begin
          nxt_state = ST_IDLE;
          nxt_both = 1'b0;
        end
      end
      ST_NUDGE: begin
        goal = (remain_ff <= up_steps_ff) ? floor_spd : tgt;
        if (remain_ff == '0) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state, direction and handshake outputs
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_ff <= ST_IDLE;
      dir_ff <= 1'b0;
      both_seen_ff <= 1'b0;
      ready_ff <= 1'b1;
      move_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      dir_ff <= nxt_dir;
      both_seen_ff <= nxt_both;
      ready_ff <= (nxt_state == ST_IDLE);
      move_ff <= (nxt_state == ST_LOAD) | (nxt_state == ST_RUN) | (nxt_state == ST_NUDGE);
    end
  end

  // linear speed ramp, one hertz per accumulator overflow
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cur_ff <= '0;
      racc_ff <= '0;
    end else if (nxt_state != ST_RUN && nxt_state != ST_NUDGE) begin
      cur_ff <= '0;
      racc_ff <= '0;
    end else if (cur_ff == '0) begin
      cur_ff <= floor_spd; // motion starts at the starting speed
      racc_ff <= '0;
    end else if (cur_ff != goal) begin
      cur_ff <= ramp_hit ? ((cur_ff < goal) ? cur_ff + 1'b1 : cur_ff - 1'b1) : cur_ff;
      racc_ff <= ramp_hit ? ramp_sum - den : ramp_sum;
    end else begin
      racc_ff <= '0;
    end
  end

  assign moving = (state_ff == ST_RUN) | ((state_ff == ST_NUDGE) & (remain_ff != '0));
  assign ph_sum = ph_ff + PH_W'(cur_ff);
  assign step_hit = moving & (ph_sum >= PH_W'(STEP_CLK_HZ));

  // step phase accumulator and step pulse
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ph_ff <= '0;
      step_ff <= 1'b0;
    end else begin
      ph_ff <= !moving ? '0 : (step_hit ? ph_sum - PH_W'(STEP_CLK_HZ) : ph_sum);
      step_ff <= step_hit;
    end
  end

  // position and nudge travel counters
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pos_ff <= '0;
      remain_ff <= '0;
      up_steps_ff <= '0;
    end else begin
      if (step_hit) begin
        pos_ff <= dir_ff ? pos_ff - 1'b1 : pos_ff + 1'b1;
      end
      if (state_ff == ST_IDLE) begin
        remain_ff <= nudge_amount_ff;
        up_steps_ff <= '0;
      end else if (step_hit && state_ff == ST_NUDGE) begin
        remain_ff <= remain_ff - 1'b1;
        up_steps_ff <= (cur_ff < goal) ? up_steps_ff + 1'b1 : up_steps_ff;
      end
    end
  end

  assign READY_OUT = ready_ff;
  assign MOVE_OUT = move_ff;
  assign STEP_OUT = step_ff;
  assign DIR_OUT = dir_ff;
endmodule : cnms_top

// [cnms_pkg.sv]
// constants, field layout and state type of the continuous and nudge motion sequencer
// assumes a single 125 MHz clock and a classic wishbone register bus with 32-bit data
//
// Contract
// - six select inputs form entry index 0..63
// - a run input starts continuous motion
// - ready drops at start, returns after stop
// - new selection while running ramps to new speed
// - run release decelerates, same direction re-accelerates
// - opposite run while decelerating: halt, then reverse
// - both run inputs together decelerate to standstill
// - moving output drops at that standstill
// - ready returns only after both runs release
// - select and run in same update accepted
// - separate mode: rate from entry speed and time
// - common mode: rate from shared accel/decel time
// - nudge inputs start fixed moves, positive or negative
// - nudge amount 1..8388607 steps, default one
// - nudge start 0..1e6 Hz (500), speed 1000
// - nudge ramp 1..1e6, unit ms/kHz or s
// - host releases nudge; ready returns at completion
// - teaching stores position, forces absolute mode
// - teaching moves use nudge speed, ramp, start
// - entry speed 1..1e6 Hz, default 1000
// - ramp type selects separate or common values
package cnms_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SEC_NS = 1000000000;
  localparam int unsigned TICK_TIME_NS = 1000000; // one ramp unit of 0.001 s
  localparam int unsigned MSKHZ_NUM = 1000000; // Hz per ms for a ramp of 0.001 ms/kHz
  // ****************************************************************
  // widths and ranges
  // ****************************************************************
  localparam int SPD_W = 20;
  localparam int POS_W = 24;
  localparam int IDX_W = 6;
  localparam int ACC_W = 40;
  localparam int PH_W = 28;
  localparam int ENT_DEPTH = 64;
  localparam logic [31:0] SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX = 32'h000f_4240; // 1,000,000
  localparam logic [31:0] START_MIN = 32'h0000_0000;
  localparam logic [31:0] RAMP_MIN = 32'h0000_0001;
  localparam logic [31:0] RAMP_MAX = 32'h000f_4240;
  localparam logic [31:0] AMOUNT_MIN = 32'h0000_0001;
  localparam logic [31:0] AMOUNT_MAX = 32'h007f_ffff; // 8,388,607
  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [SPD_W-1:0] RST_SPEED = 20'h003e8; // 1000 Hz
  localparam logic [SPD_W-1:0] RST_RAMP = 20'h003e8;
  localparam logic [SPD_W-1:0] RST_START = 20'h001f4; // 500 Hz
  localparam logic [POS_W-2:0] RST_AMOUNT = 23'h000001;
  // ****************************************************************
  // entry word layout: speed, accel, decel, position, absolute flag
  // ****************************************************************
  localparam int ENT_SPD_LSB = 0;
  localparam int ENT_ACC_LSB = 20;
  localparam int ENT_DEC_LSB = 40;
  localparam int ENT_POS_LSB = 60;
  localparam int ENT_ABS_BIT = 84;
  localparam int ENT_W = 85;
  localparam logic [ENT_W-1:0] ENT_RST = {1'b0, 24'h000000, RST_RAMP, RST_RAMP, RST_SPEED};
  // ****************************************************************
  // register byte offsets and control bits
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_START_SPEED = 8'h08;
  localparam logic [7:0] OFF_SHARED_ACC = 8'h0c;
  localparam logic [7:0] OFF_SHARED_DEC = 8'h10;
  localparam logic [7:0] OFF_NUDGE_AMOUNT = 8'h14;
  localparam logic [7:0] OFF_NUDGE_SPEED = 8'h18;
  localparam logic [7:0] OFF_NUDGE_START = 8'h1c;
  localparam logic [7:0] OFF_NUDGE_RAMP = 8'h20;
  localparam logic [7:0] OFF_POSITION = 8'h24;
  localparam logic [7:0] OFF_CUR_SPEED = 8'h28;
  localparam logic [7:0] OFF_ENT_IDX = 8'h2c;
  localparam logic [7:0] OFF_ENT_SPEED = 8'h30;
  localparam logic [7:0] OFF_ENT_ACC = 8'h34;
  localparam logic [7:0] OFF_ENT_DEC = 8'h38;
  localparam logic [7:0] OFF_ENT_POS = 8'h3c;
  localparam logic [7:0] OFF_ENT_MODE = 8'h40;
  localparam int CTRL_COMMON_BIT = 0;
  localparam int CTRL_UNIT_S_BIT = 1;
  localparam int CTRL_TEACH_BIT = 8;
  localparam int CTRL_NPOS_BIT = 9;
  localparam int CTRL_NNEG_BIT = 10;
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_HOLD, ST_NUDGE} cnms_state_type;
endpackage : cnms_pkg

// [cnms_entry_mem.sv]
// operation-data entry store: one write port with bit mask, two registered read ports
// assumes writer and readers share the system clock
module cnms_entry_mem import cnms_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic we,
  input wire logic [IDX_W-1:0] waddr,
  input wire logic [ENT_W-1:0] wmask,
  input wire logic [ENT_W-1:0] wdata,
  input wire logic [IDX_W-1:0] raddr_a,
  output logic [ENT_W-1:0] rdata_a,
  input wire logic [IDX_W-1:0] raddr_b,
  output logic [ENT_W-1:0] rdata_b
);
  logic [ENT_W-1:0] mem_ff [ENT_DEPTH];

  // masked write; reset loads every entry with its default values
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      for (int i = 0; i < ENT_DEPTH; i++) begin
        mem_ff[i] <= ENT_RST;
      end
    end else if (we) begin
      mem_ff[waddr] <= (mem_ff[waddr] & ~wmask) | (wdata & wmask);
    end
  end

  // registered read ports
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_a <= ENT_RST;
      rdata_b <= ENT_RST;
    end else begin
      rdata_a <= mem_ff[raddr_a];
      rdata_b <= mem_ff[raddr_b];
    end
  end
endmodule : cnms_entry_mem

// [cnms_properties.sv]
// checker on the sequencer top ports
// assumes a bind onto cnms_top
module cnms_properties (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [31:0] WB_DAT_O,
  input wire logic FORWARD_RUN_IN,
  input wire logic REVERSE_RUN_IN,
  input wire logic READY_OUT,
  input wire logic MOVE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // bus and run properties
  // ****
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
  a_run_start: assert property ((READY_OUT && FORWARD_RUN_IN && !REVERSE_RUN_IN) [*3] |=> !READY_OUT && MOVE_OUT)
    else $error("run not started");
  a_both_refused: assert property ((READY_OUT && FORWARD_RUN_IN && REVERSE_RUN_IN) [*3] |=> READY_OUT)
    else $error("started on both");
  a_move_ready: assert property (MOVE_OUT |-> !READY_OUT) else $error("ready while moving");
  a_ready_fall: assert property ($fell(READY_OUT) |-> MOVE_OUT) else $error("ready fell at rest");
  a_hold_both: assert property ((!MOVE_OUT && !READY_OUT && !FORWARD_RUN_IN && !REVERSE_RUN_IN) [*3] |=> READY_OUT)
    else $error("held after both runs released");
endmodule : cnms_properties
bind cnms_top cnms_properties chk (.SYS_CLK(SYS_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .FORWARD_RUN_IN(FORWARD_RUN_IN), .REVERSE_RUN_IN(REVERSE_RUN_IN),
  .READY_OUT(READY_OUT), .MOVE_OUT(MOVE_OUT));

// [cnms_host.sv]
// host model driving run, select and nudge pins
// assumes the sequencer ready output on the system clock
module cnms_host (
  input wire logic clk,
  input wire logic ready,
  output logic forward_run_in,
  output logic reverse_run_in,
  output logic [5:0] sel,
  output logic npos,
  output logic nneg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // pin drivers
  // ****
  initial {forward_run_in, reverse_run_in, sel, npos, nneg} = '0;
  // run pins and selection in one update
  task automatic set(input logic f, input logic r, input logic [5:0] s);
    @(posedge clk);
    {forward_run_in, reverse_run_in, sel} <= {f, r, s};
  endtask : set
  // forward run from ready, selection settled first
  task automatic run(input logic [5:0] s);
    wait (ready === 1'b1);
    set(1'b0, 1'b0, s);
    set(1'b1, 1'b0, s);
  endtask : run
  // nudge, released once ready drops
  task automatic nudge(input logic neg);
    wait (ready === 1'b1);
    @(posedge clk);
    {npos, nneg} <= {!neg, neg};
    wait (ready === 1'b0);
    @(posedge clk);
    {npos, nneg} <= 2'b00;
  endtask : nudge
endmodule : cnms_host

// [cnms_top_test.sv]
// bench of the motion sequencer: bus, run, nudge, teach
// assumes shortened tick and step clock parameters
module cnms_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ack, rdy, mov, forward_run_in, reverse_run_in, np, nn, stp, dirq;
  logic [3:0] be = 4'hf;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, q, amt, spd;
  logic [5:0] idx, sel;
  int failures = 0, compares = 0, cycles = 0, steps = 0, seed = 32'h1af2;
  // ****
  // clock, design, host
  // ****
  always #4 clk = ~clk;
  cnms_top #(.TICK_CYC(100), .STEP_CLK_HZ(100000)) DUT (.SYS_CLK(clk), .RESET(rst), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(be), .WB_STB_I(cyc), .WB_CYC_I(cyc),
    .WB_ACK_O(ack), .FORWARD_RUN_IN(forward_run_in), .REVERSE_RUN_IN(reverse_run_in), .DATA_SELECT_B0(sel[0]), .DATA_SELECT_B1(sel[1]),
    .DATA_SELECT_B2(sel[2]), .DATA_SELECT_B3(sel[3]), .DATA_SELECT_B4(sel[4]), .DATA_SELECT_B5(sel[5]),
    .STEP_NUDGE_POS(np), .STEP_NUDGE_NEG(nn), .READY_OUT(rdy), .MOVE_OUT(mov), .STEP_OUT(stp), .DIR_OUT(dirq));
  cnms_host host (.clk(clk), .ready(rdy), .forward_run_in(forward_run_in), .reverse_run_in(reverse_run_in), .sel(sel), .npos(np), .nneg(nn));
  // expected value of a clamped 1..1e6 setting
  function automatic logic [31:0] lim(input logic [31:0] v);
    return v > 32'hf4240 ? 32'hf4240 : (v == 32'h0 ? 32'h1 : v);
  endfunction : lim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic print_verdict;
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // hang limit
  always @(posedge clk) begin
    cycles++;
    if (stp === 1'b1) steps++; // step pulses seen on the pin
    if (cycles == 32'hc350) begin
      failures++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h04);
    chk(q, 32'h1);
    rd(8'h44);
    chk(q, 32'h0);
    spd = $random(seed) & 32'h1fffff;
    bus(1'b1, 8'h0c, spd);
    rd(8'h0c);
    chk(q, lim(spd));
    be <= 4'h1;
    bus(1'b1, 8'h10, spd);
    be <= 4'hf;
    rd(8'h10);
    chk(q, 32'h300 | (spd & 32'hff));
    host.set(1'b1, 1'b1, 6'h0);
    repeat (8) @(posedge clk);
    rd(8'h04);
    chk(q & 32'h77, 32'h1);
    host.set(1'b0, 1'b0, 6'h0);
    amt = 32'h1 + ($random(seed) & 32'h7);
    bus(1'b1, 8'h14, amt);
    host.nudge(1'b0);
    wait (rdy === 1'b1);
    rd(8'h24);
    chk(q, amt);
    idx = 6'($random(seed)) | 6'h1;
    bus(1'b1, 8'h2c, {26'h0, idx});
    bus(1'b1, 8'h00, 32'h100);
    rd(8'h3c);
    chk(q, amt);
    rd(8'h40);
    chk(q, 32'h1);
    host.nudge(1'b1);
    wait (rdy === 1'b1);
    rd(8'h24);
    chk(q, 32'h0);
    chk({31'h0, dirq}, 32'h1);
    bus(1'b1, 8'h00, 32'h203);
    wait (rdy === 1'b0);
    wait (rdy === 1'b1);
    rd(8'h24);
    chk(q, amt);
    chk(steps, 3 * amt);
    rd(8'h00);
    chk(q, 32'h3);
    bus(1'b1, 8'h00, 32'h0);
    spd = 32'h7d0 + ($random(seed) & 32'h3ff);
    bus(1'b1, 8'h30, spd);
    host.run(idx);
    repeat (4000) @(posedge clk);
    rd(8'h28);
    chk(q, spd);
    host.set(1'b1, 1'b0, 6'h0);
    repeat (3000) @(posedge clk);
    rd(8'h28);
    chk(q, 32'h3e8);
    host.set(1'b0, 1'b0, 6'h0);
    wait (rdy === 1'b1);
    rd(8'h04);
    chk(q & 32'h77, 32'h1);
    host.run(6'h0);
    repeat (300) @(posedge clk);
    host.set(1'b1, 1'b1, 6'h0);
    wait (mov === 1'b0);
    rd(8'h04);
    chk(q & 32'h77, 32'h30);
    host.set(1'b0, 1'b0, 6'h0);
    wait (rdy === 1'b1);
    rd(8'h04);
    chk(q & 32'h77, 32'h1);
    print_verdict();
  end
endmodule : cnms_top_test
